// >>> pgcs_regs.sv
// power-good configuration, fault latches, clock select and soft reset
`timescale 1ns/1ps
`default_nettype none
`include "pgcs_defs.svh"

module pgcs_regs
    import pgcs_pkg::*;
#(
    parameter int LOSS_CYC = `PGCS_LOSS_CYC
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [`PGCS_NUM_OUT-1:0] uv_ok_i,
    input wire logic [`PGCS_NUM_OUT-1:0] ov_ok_i,
    input wire logic [`PGCS_NUM_OUT-1:0] out_enabled_i,
    input wire logic thermal_warn_i,
    input wire logic run_mode_i,
    input wire logic sync_clock_input_i,
    output logic power_good_out_o,
    output logic power_good_oe_o,
    output logic pll_enable_o,
    output logic use_ext_clock_o,
    output logic [5:0] ext_rate_mhz_o,
    output logic serial_reset_o,
    output logic otp_reload_o
);
    localparam int NOUT = `PGCS_NUM_OUT;
    localparam int SYNC_W = 3 * NOUT + 3;

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    logic [SYNC_W-1:0] sync1_reg, sync2_reg;
    logic [NOUT-1:0] uv_s, ov_s, en_s;
    logic twarn_s, run_s, clkpin_s;
    pgcs_rst_state_type state_reg, state_next;
    logic in_run, in_clear;
    logic pll_en_reg, pll_en_next;
    logic [`PGCS_CLK_CODE_MSB:0] code_reg, code_next;
    logic [7:0] pgout_reg, pgout_next;
    logic [`PGCS_PGMODE_MSB:0] pgmode_reg, pgmode_next;
    logic [NOUT-1:0] fault_reg, fault_next;
    logic pgdrop_reg, pgdrop_next;
    logic clkchg_reg, clkchg_next;
    logic rstocc_reg, rstocc_next;
    logic pg_active_reg, pg_active_next;
    logic pg_out_reg, pg_out_next;
    logic pg_oe_reg, pg_oe_next;
    logic pll_out_reg, pll_out_next;
    logic ext_reg, ext_next;
    logic [5:0] rate_reg, rate_next;
    logic ser_rst_reg, ser_rst_next;
    logic otp_reg, otp_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [NOUT-1:0] out_valid, window_on, fault_set, fault_clr, mon_eff;
    logic [NOUT-1:0] stuck_w;
    logic fault_wr, flag1_wr, flag2_wr;
    logic pg_live, pg_latch_ok, pg_level, pg_drop_evt;
    logic clk_present, clk_change, code_ok;

    function automatic logic hit(input logic stb, input logic [7:0] a,
                                 input logic [7:0] target);
        return stb && (a == target);
    endfunction

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {sync_clock_input_i, run_mode_i, thermal_warn_i,
                          out_enabled_i, ov_ok_i, uv_ok_i};
            sync2_reg <= sync1_reg;
        end
    end
    assign {clkpin_s, run_s, twarn_s, en_s, ov_s, uv_s} = sync2_reg;

    pgcs_clk_presence #(
        .LOSS_CYC(LOSS_CYC)
    ) u_presence (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .pin_i(clkpin_s),
        .present_o(clk_present),
        .change_o(clk_change)
    );

    // ------------------------------------------------------------------------
    // soft reset sequencer
    // ------------------------------------------------------------------------
    assign in_run = state_reg == PGCS_ST_RUN;
    assign in_clear = state_reg == PGCS_ST_CLEAR;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PGCS_ST_RUN: begin
                if (hit(reg_wr_i, reg_addr_i, `PGCS_ADDR_RESET) &&
                    reg_wdata_i[`PGCS_SWRST_BIT]) begin
                    state_next = PGCS_ST_CLEAR;
                end
            end
            PGCS_ST_CLEAR: begin
                state_next = PGCS_ST_RELOAD;
            end
            PGCS_ST_RELOAD: begin
                state_next = PGCS_ST_RUN;
            end
            default: begin
                state_next = PGCS_ST_RUN;
            end
        endcase
        ser_rst_next = state_next == PGCS_ST_CLEAR;
        otp_next = state_next == PGCS_ST_RELOAD;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= PGCS_ST_RUN;
            ser_rst_reg <= 1'b0;
            otp_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ser_rst_reg <= ser_rst_next;
            otp_reg <= otp_next;
        end
    end

    // ------------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------------
    always_comb begin
        pll_en_next = pll_en_reg;
        code_next = code_reg;
        pgout_next = pgout_reg;
        pgmode_next = pgmode_reg;
        if (in_clear) begin
            pll_en_next = `PGCS_PLL_EN_RST;
            code_next = `PGCS_CODE_RST;
            pgout_next = `PGCS_PGOUT_RST;
            pgmode_next = `PGCS_PGMODE_RST;
        end else if (in_run) begin
            // bits 7 and 5 are not stored; host keeps bit 5 at zero
            if (hit(reg_wr_i, reg_addr_i, `PGCS_ADDR_CLK)) begin
                pll_en_next = reg_wdata_i[`PGCS_CLK_PLL_BIT];
                code_next = reg_wdata_i[`PGCS_CLK_CODE_MSB:0];
            end
            if (hit(reg_wr_i, reg_addr_i, `PGCS_ADDR_PGOUT)) begin
                pgout_next = reg_wdata_i;
            end
            if (hit(reg_wr_i, reg_addr_i, `PGCS_ADDR_PGMODE)) begin
                pgmode_next = reg_wdata_i[`PGCS_PGMODE_MSB:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pll_en_reg <= `PGCS_PLL_EN_RST;
            code_reg <= `PGCS_CODE_RST;
            pgout_reg <= `PGCS_PGOUT_RST;
            pgmode_reg <= `PGCS_PGMODE_RST;
        end else begin
            pll_en_reg <= pll_en_next;
            code_reg <= code_next;
            pgout_reg <= pgout_next;
            pgmode_reg <= pgmode_next;
        end
    end

    // ------------------------------------------------------------------------
    // per-output validity and fault latch terms
    // ------------------------------------------------------------------------
    assign fault_wr = in_run && hit(reg_wr_i, reg_addr_i, `PGCS_ADDR_FAULT);
    assign flag1_wr = in_run && hit(reg_wr_i, reg_addr_i, `PGCS_ADDR_FLAG1);
    assign flag2_wr = in_run && hit(reg_wr_i, reg_addr_i, `PGCS_ADDR_FLAG2);

    genvar gi;
    generate
        for (gi = 0; gi < NOUT; gi++) begin : g_out
            assign window_on[gi] = (gi >= `PGCS_FIRST_LINREG) ?
                pgout_reg[`PGCS_WIN_LIN_BIT] :
                pgout_reg[`PGCS_WIN_SW_BIT];
            assign out_valid[gi] = uv_s[gi] & (ov_s[gi] | ~window_on[gi]);
            assign fault_set[gi] = mon_eff[gi] & ~out_valid[gi];
            assign fault_clr[gi] = fault_wr & reg_wdata_i[gi] &
                                   out_valid[gi];
        end
    endgenerate
    assign stuck_w = fault_reg & ~out_valid;

    // ------------------------------------------------------------------------
    // power-good combine and pin drive
    // ------------------------------------------------------------------------
    always_comb begin
        // gated mode skips outputs whose regulator is off
        mon_eff = pgout_reg[`PGCS_SEL_MSB:0] &
                  (pgmode_reg[`PGCS_MODE_BIT] ? {NOUT{1'b1}} : en_s);
        pg_live = &(~mon_eff | out_valid);
        pg_latch_ok = ~|(fault_reg | fault_set);
        pg_active_next = (pgmode_reg[`PGCS_FGATE_BIT] ? pg_latch_ok : pg_live)
                         & ~(pgmode_reg[`PGCS_TWARN_BIT] & twarn_s);
        pg_level = pg_active_next ^ pgout_reg[`PGCS_POL_BIT];
        if (pgout_reg[`PGCS_OD_BIT]) begin
            pg_out_next = 1'b0;
            pg_oe_next = ~pg_level;
        end else begin
            pg_out_next = pg_level;
            pg_oe_next = 1'b1;
        end
        pg_drop_evt = pg_active_reg & ~pg_active_next;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pg_active_reg <= 1'b0;
            pg_out_reg <= 1'b0;
            pg_oe_reg <= 1'b0;
        end else begin
            pg_active_reg <= pg_active_next;
            pg_out_reg <= pg_out_next;
            pg_oe_reg <= pg_oe_next;
        end
    end

    // ------------------------------------------------------------------------
    // fault latches and event flags; a set beats a clear
    // ------------------------------------------------------------------------
    always_comb begin
        fault_next = fault_reg;
        pgdrop_next = pgdrop_reg;
        clkchg_next = clkchg_reg;
        rstocc_next = rstocc_reg;
        if (in_clear) begin
            fault_next = `PGCS_FAULT_RST;
            pgdrop_next = 1'b0;
            clkchg_next = 1'b0;
            rstocc_next = 1'b1;
        end else begin
            fault_next = (fault_reg & ~fault_clr) | fault_set;
            pgdrop_next = (pgdrop_reg &
                ~(flag1_wr & reg_wdata_i[`PGCS_PGDROP_BIT])) |
                pg_drop_evt;
            clkchg_next = (clkchg_reg &
                ~(flag1_wr & reg_wdata_i[`PGCS_CLKCHG_BIT])) |
                (pll_en_reg & clk_change);
            rstocc_next = rstocc_reg &
                ~(flag2_wr & reg_wdata_i[`PGCS_RSTOCC_BIT]);
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fault_reg <= `PGCS_FAULT_RST;
            pgdrop_reg <= 1'b0;
            clkchg_reg <= 1'b0;
            rstocc_reg <= 1'b0;
        end else begin
            fault_reg <= fault_next;
            pgdrop_reg <= pgdrop_next;
            clkchg_reg <= clkchg_next;
            rstocc_reg <= rstocc_next;
        end
    end

    // ------------------------------------------------------------------------
    // clock source selection
    // ------------------------------------------------------------------------
    always_comb begin
        code_ok = code_reg <= `PGCS_CODE_MAX;
        pll_out_next = pll_en_reg & run_s;
        ext_next = pll_out_next & clk_present & code_ok;
        rate_next = {1'b0, code_reg} + `PGCS_MHZ_STEP;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pll_out_reg <= 1'b0;
            ext_reg <= 1'b0;
            rate_reg <= '0;
        end else begin
            pll_out_reg <= pll_out_next;
            ext_reg <= ext_next;
            rate_reg <= rate_next;
        end
    end

    // ------------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------------
    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd_i) begin
            rdata_next = 8'h00;
            case (reg_addr_i)
                `PGCS_ADDR_CLK: begin
                    rdata_next[`PGCS_CLK_PLL_BIT] = pll_en_reg;
                    rdata_next[`PGCS_CLK_CODE_MSB:0] = code_reg;
                end
                `PGCS_ADDR_PGOUT: rdata_next = pgout_reg;
                `PGCS_ADDR_PGMODE: rdata_next[`PGCS_PGMODE_MSB:0] = pgmode_reg;
                `PGCS_ADDR_FAULT: rdata_next[NOUT-1:0] = fault_reg;
                `PGCS_ADDR_RESET: rdata_next[`PGCS_SWRST_BIT] = in_clear;
                `PGCS_ADDR_FLAG1: begin
                    rdata_next[`PGCS_PGDROP_BIT] = pgdrop_reg;
                    rdata_next[`PGCS_CLKCHG_BIT] = clkchg_reg;
                end
                `PGCS_ADDR_FLAG2: rdata_next[`PGCS_RSTOCC_BIT] = rstocc_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign power_good_out_o = pg_out_reg;
    assign power_good_oe_o = pg_oe_reg;
    assign pll_enable_o = pll_out_reg;
    assign use_ext_clock_o = ext_reg;
    assign ext_rate_mhz_o = rate_reg;
    assign serial_reset_o = ser_rst_reg;
    assign otp_reload_o = otp_reg;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    chk_pll_off_rc: assert property (
        !pll_en_reg |=> !pll_enable_o && !use_ext_clock_o)
        else $error("pll or external clock active while pll disabled");
    chk_ext_auto: assert property (
        pll_en_reg && run_s && clk_present && code_ok |=> use_ext_clock_o)
        else $error("external clock not selected when present");
    chk_clk_event: assert property (
        in_run && pll_en_reg && clk_change |=> clkchg_reg)
        else $error("clock change flag not set");
    chk_rate_code: assert property (
        1'b1 |=> ext_rate_mhz_o == {1'b0, $past(code_reg)} + `PGCS_MHZ_STEP)
        else $error("expected rate is not code plus one");
    chk_pg_pushpull: assert property (
        !pgout_reg[`PGCS_OD_BIT] |=> power_good_oe_o &&
        (power_good_out_o == ($past(pg_active_next) ^
                              $past(pgout_reg[`PGCS_POL_BIT]))))
        else $error("push-pull power-good level wrong");
    chk_pg_opendrain: assert property (
        pgout_reg[`PGCS_OD_BIT] |=> !power_good_out_o)
        else $error("open-drain power-good drives high");
    chk_twarn_gate: assert property (
        pgmode_reg[`PGCS_TWARN_BIT] && twarn_s |=> !pg_active_reg)
        else $error("power-good active during thermal warning");
    chk_fault_gate: assert property (
        pgmode_reg[`PGCS_FGATE_BIT] && (fault_reg != '0) |=> !pg_active_reg)
        else $error("power-good active with latched fault");
    chk_fault_set: assert property (
        !in_clear && (fault_set != '0) |=>
        (fault_reg & $past(fault_set)) == $past(fault_set))
        else $error("fault bit did not latch");
    chk_fault_hold: assert property (
        !in_clear && (stuck_w != '0) |=>
        (fault_reg & $past(stuck_w)) == $past(stuck_w))
        else $error("fault bit cleared while output invalid");
    chk_swrst_seq: assert property (
        in_clear |=> otp_reload_o ##1 in_run && rstocc_reg &&
        pgout_reg == `PGCS_PGOUT_RST)
        else $error("soft reset sequence wrong");
    chk_pg_drop: assert property (
        !in_clear && pg_active_reg && !pg_active_next |=> pgdrop_reg)
        else $error("power-good drop flag not set");
    chk_rsvd_zero: assert property (
        reg_rd_i && reg_addr_i == `PGCS_ADDR_PGMODE |=>
        reg_rdata_o[7:`PGCS_PGMODE_MSB+1] == '0)
        else $error("reserved bits read nonzero");
endmodule
`default_nettype wire

// >>> pgcs_defs.svh
// register map, field positions, reset values and timing for pgcs
`ifndef PGCS_DEFS_SVH
`define PGCS_DEFS_SVH
// Behaviour
// - pll enable clear: run from internal rc oscillator, pll kept off
// - pll enable set: pll on in standby/active, external clock used if present
// - pll enabled: external clock starting or stopping raises an event
// - 5-bit rate code gives expected frequency code+1 MHz; 0x18-0x1f reserved
// - polarity clear: output high when valid; set: low when valid
// - drive type clear: push-pull at analog supply; set: open-drain
// - linreg window set checks over and under voltage, else under only
// - switcher window set checks over and under voltage, else under only
// - four select bits include each regulator output in power-good monitoring
// - thermal gating set: power-good inactive while thermal warning active
// - fault gating set: power-good follows latched faults, else live state
// - mode bit: gated when clear, continuous when set; resets to gated
// - fault bit latches when selected output drives power-good inactive
// - writing one clears a fault bit only while that output is valid
// - soft reset restores defaults, reloads otp, resets serial interface
// - soft reset bit clears itself; later reads show zero
// - clock appear/disappear sets latched flag; write one clears
// - power-good active to inactive sets latched flag; write one clears
// - soft reset sets latched reset-occurred flag until written one

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define PGCS_ADDR_CLK 8'h14
`define PGCS_ADDR_PGOUT 8'h15
`define PGCS_ADDR_PGMODE 8'h16
`define PGCS_ADDR_FAULT 8'h17
`define PGCS_ADDR_RESET 8'h18
`define PGCS_ADDR_FLAG1 8'h19
`define PGCS_ADDR_FLAG2 8'h1A

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define PGCS_CLK_PLL_BIT 6
`define PGCS_CLK_CODE_MSB 4
`define PGCS_PLL_EN_RST 1'b0
`define PGCS_CODE_RST 5'h01
`define PGCS_CODE_MAX 5'h17
`define PGCS_MHZ_STEP 6'h01
`define PGCS_POL_BIT 7
`define PGCS_OD_BIT 6
`define PGCS_WIN_LIN_BIT 5
`define PGCS_WIN_SW_BIT 4
`define PGCS_SEL_MSB 3
`define PGCS_PGOUT_RST 8'h73
`define PGCS_TWARN_BIT 2
`define PGCS_FGATE_BIT 1
`define PGCS_MODE_BIT 0
`define PGCS_PGMODE_MSB 2
`define PGCS_PGMODE_RST 3'h4
`define PGCS_FAULT_RST 4'h0
`define PGCS_SWRST_BIT 0
`define PGCS_PGDROP_BIT 7
`define PGCS_CLKCHG_BIT 4
`define PGCS_RSTOCC_BIT 0
`define PGCS_NUM_OUT 4
`define PGCS_FIRST_LINREG 2

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define PGCS_CLK_PERIOD_NS 100
`define PGCS_LOSS_NS 10000
`define PGCS_LOSS_CYC \
    ((`PGCS_LOSS_NS + `PGCS_CLK_PERIOD_NS - 1) / `PGCS_CLK_PERIOD_NS)
`endif

// >>> pgcs_pkg.sv
// types shared by the power-good and clock-select register block
`default_nettype none
package pgcs_pkg;
    typedef enum logic [2:0] {
        PGCS_ST_RUN = 3'h1,
        PGCS_ST_CLEAR = 3'h2,
        PGCS_ST_RELOAD = 3'h4
    } pgcs_rst_state_type;
endpackage
`default_nettype wire

// >>> pgcs_clk_presence.sv
// external clock activity detector
`timescale 1ns/1ps
`default_nettype none
module pgcs_clk_presence #(
    parameter int LOSS_CYC = 100
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic pin_i,
    output logic present_o,
    output logic change_o
);
    localparam int CW = $clog2(LOSS_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(LOSS_CYC - 1);

    logic prev_reg, prev_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic present_reg, present_next;
    logic change_reg, change_next;

    // ------------------------------------------------------------------------
    // any level change restarts the loss timer
    // ------------------------------------------------------------------------
    always_comb begin
        prev_next = pin_i;
        cnt_next = cnt_reg;
        present_next = present_reg;
        if (pin_i != prev_reg) begin
            cnt_next = '0;
            present_next = 1'b1;
        end else if (cnt_reg == LAST) begin
            present_next = 1'b0;
        end else begin
            cnt_next = cnt_reg + 1'b1;
        end
        change_next = present_next != present_reg;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_reg <= 1'b0;
            cnt_reg <= '0;
            present_reg <= 1'b0;
            change_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
            cnt_reg <= cnt_next;
            present_reg <= present_next;
            change_reg <= change_next;
        end
    end

    assign present_o = present_reg;
    assign change_o = change_reg;
endmodule
`default_nettype wire

// >>> pgcs_host.sv
// host-side register access model for pgcs_regs
`timescale 1ns/1ps
`default_nettype none
module pgcs_host (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= (a == 8'h14) ? (d & 8'hdf) : d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~wdata_o;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// >>> tb_pgcs_regs.sv
// self-checking testbench for pgcs_regs
`timescale 1ns/1ps
`default_nettype none
module tb_pgcs_regs;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] ad, wd, rdata, v;
    logic wr, rd, po, poe, pll, ext, srst, otp;
    logic thermal = 1'b0, run = 1'b0, sclk = 1'b0, crun = 1'b0;
    logic [3:0] uv = 4'hf, ov = 4'hf, oen = 4'hf;
    logic [5:0] mhz;
    logic [7:0] dflt [7] = '{8'h01, 8'h73, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
    int bad_count = 0, total_checks = 0, pulses = 0;
    pgcs_regs #(.LOSS_CYC(4)) pgcs_regs_i (.clk_i(clk_i), .rstn_i(rstn_i),
        .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .uv_ok_i(uv), .ov_ok_i(ov), .out_enabled_i(oen),
        .thermal_warn_i(thermal), .run_mode_i(run),
        .sync_clock_input_i(sclk), .power_good_out_o(po),
        .power_good_oe_o(poe), .pll_enable_o(pll), .use_ext_clock_o(ext),
        .ext_rate_mhz_o(mhz), .serial_reset_o(srst), .otp_reload_o(otp));
    pgcs_host pgcs_host_i (.clk_i(clk_i), .rdata_i(rdata), .addr_o(ad),
        .wdata_o(wd), .wr_o(wr), .rd_o(rd));
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (crun) sclk <= ~sclk;
        pulses <= pulses + int'(srst === 1'b1) + int'(otp === 1'b1);
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        pgcs_host_i.wr(a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        pgcs_host_i.rd(a, v);
        chk(v, exp);
    endtask
    task automatic pin(input logic [1:0] e);
        repeat (6) @(posedge clk_i);
        chk({6'h00, poe, po}, {6'h00, e});
    endtask
    task automatic wrap_up;
        if (bad_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        bad_count++;
        wrap_up;
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        foreach (dflt[i]) rc(8'(8'h14 + i), dflt[i]);
        rc(8'h20, 8'h00);
        w(8'h16, 8'hff);
        rc(8'h16, 8'h07);
        w(8'h16, 8'h04);
        pin(2'b00);
        w(8'h15, 8'h03);
        pin(2'b11);
        w(8'h15, 8'h83);
        pin(2'b10);
        w(8'h15, 8'h03);
        @(posedge clk_i);
        uv <= 4'h7;
        pin(2'b11);
        oen <= 4'h6;
        uv <= 4'h6;
        pin(2'b11);
        w(8'h16, 8'h05);
        pin(2'b10);
        oen <= 4'hf;
        pin(2'b10);
        rc(8'h17, 8'h01);
        w(8'h17, 8'h01);
        rc(8'h17, 8'h01);
        rc(8'h19, 8'h80);
        uv <= 4'hf;
        ov <= 4'he;
        pin(2'b11);
        w(8'h17, 8'h01);
        rc(8'h17, 8'h00);
        w(8'h15, 8'h13);
        pin(2'b10);
        w(8'h16, 8'h06);
        ov <= 4'hf;
        pin(2'b10);
        w(8'h17, 8'h01);
        pin(2'b11);
        thermal <= 1'b1;
        pin(2'b10);
        w(8'h16, 8'h02);
        pin(2'b11);
        thermal <= 1'b0;
        run <= 1'b1;
        w(8'h14, 8'h77);
        rc(8'h14, 8'h57);
        chk({2'b00, mhz}, 8'h18);
        crun <= 1'b1;
        pin(2'b11);
        chk({6'h00, pll, ext}, 8'h03);
        rc(8'h19, 8'h90);
        w(8'h14, 8'h58);
        pin(2'b11);
        chk({6'h00, pll, ext}, 8'h02);
        w(8'h19, 8'h90);
        crun <= 1'b0;
        repeat (10) @(posedge clk_i);
        rc(8'h19, 8'h10);
        w(8'h14, 8'h01);
        pin(2'b11);
        chk({6'h00, pll, ext}, 8'h00);
        w(8'h19, 8'h90);
        rc(8'h19, 8'h00);
        w(8'h18, 8'h01);
        repeat (3) @(posedge clk_i);
        rc(8'h18, 8'h00);
        rc(8'h15, 8'h73);
        rc(8'h1a, 8'h01);
        chk(8'(pulses), 8'h02);
        w(8'h1a, 8'h01);
        rc(8'h1a, 8'h00);
        wrap_up;
    end
endmodule
`default_nettype wire
